/* hw/serial_multi_io_slave.v */
// serial host slave: dual/quad i/o register reads and multi-dword writes
`timescale 1ns/1ps
`include "serial_slave_map.vh"
module serial_multi_io_slave #(
  parameter [7:0] WRITE_OPCODE = `OPC_WRITE_DEF
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // serial link pins
  input wire serial_clk,
  input wire serial_select_n,
  input wire [3:0] serial_data_lines_in,
  output wire [3:0] serial_data_lines_out,
  output wire [3:0] serial_data_lines_oe,
  // configuration
  input wire quad_instruction_protocol,
  input wire compat_mode,
  input wire [7:0] rd_dummy_init,
  input wire [7:0] rd_dummy_intra,
  input wire [7:0] rd_dummy_inter,
  input wire [7:0] wr_dummy_init,
  input wire [7:0] wr_dummy_intra,
  input wire [7:0] wr_dummy_inter,
  // register read port
  output reg rd_req_ff,
  output reg [13:0] rd_dw_ff,
  input wire rd_ack,
  input wire [31:0] rd_data,
  // register write port
  output reg wr_strobe_ff,
  output reg [11:0] wr_addr_ff,
  output reg [31:0] wr_data_ff,
  output reg [3:0] wr_be_ff,
  // status
  output reg busy_ff,
  output reg cmd_reject_ff
);

  localparam [9:0] S_IDLE = 10'h001;
  localparam [9:0] S_OPC = 10'h002;
  localparam [9:0] S_ADDR = 10'h004;
  localparam [9:0] S_LEN1 = 10'h008;
  localparam [9:0] S_LEN2 = 10'h010;
  localparam [9:0] S_RDUM = 10'h020;
  localparam [9:0] S_ROUT = 10'h040;
  localparam [9:0] S_WDUM = 10'h080;
  localparam [9:0] S_WDAT = 10'h100;
  localparam [9:0] S_IGN = 10'h200;

  // link inputs cross into ref_clk here
  wire [5:0] sync_bus;
  wire sclk_s;
  wire sel_s;
  wire [3:0] lines_s;

  // select crosses inverted: the synchroniser's reset value must read as deselected
  sync_2ff #(.WIDTH(6)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in({serial_data_lines_in, ~serial_select_n, serial_clk}),
    .sync_out_ff(sync_bus)
  );

  assign sclk_s = sync_bus[0];
  assign sel_s = sync_bus[1];
  assign lines_s = sync_bus[5:2];

  reg sclk_d_ff;
  reg [9:0] state_ff;
  reg [7:0] in_sr_ff;
  reg [2:0] in_cnt_ff;
  reg addr_hi_done_ff;
  reg [15:0] addr_ff;
  reg is_quad_ff;
  reg is_wr_ff;
  reg [13:0] len_ff;
  reg [1:0] pad_ff;
  reg [7:0] dum_ff;
  reg [1:0] lane_ff;
  reg [31:0] rd_word_ff;
  reg [11:0] wr_dw_ff;
  reg [31:0] wr_word_ff;
  reg [3:0] wr_acc_be_ff;

  wire rise = sclk_s & ~sclk_d_ff;
  wire fall = ~sclk_s & sclk_d_ff;
  wire active = sel_s;

  // address, length and dummies of a read run wide; opcode and writes run x1
  wire wide = ~is_wr_ff & ((state_ff == S_ADDR) | (state_ff == S_LEN1) |
    (state_ff == S_LEN2) | (state_ff == S_RDUM));
  reg [2:0] grp_last;
  reg [7:0] nxt_in_sr;

  always @* begin
    if (!wide) begin
      grp_last = `GRP_LAST_X1;
      nxt_in_sr = {in_sr_ff[6:0], lines_s[0]};
    end else if (is_quad_ff) begin
      grp_last = `GRP_LAST_X4;
      nxt_in_sr = {in_sr_ff[3:0], lines_s[3:0]};
    end else begin
      grp_last = `GRP_LAST_X2;
      nxt_in_sr = {in_sr_ff[5:0], lines_s[1:0]};
    end
  end

  wire byte_done = rise & (in_cnt_ff == grp_last);
  wire [15:0] nxt_addr = {addr_ff[7:0], nxt_in_sr};

  // byte merged into the write dword at the current lane, lsb lane first
  wire [4:0] wr_sh = {lane_ff, 3'b000};
  wire [31:0] nxt_wr_word = (wr_word_ff & ~(`BYTE_MASK << wr_sh)) |
    ({24'h000000, nxt_in_sr} << wr_sh);
  wire [3:0] lane_bit = 4'h1 << lane_ff;

  // read output byte selection
  wire [4:0] rd_sh = {lane_ff, 3'b000};
  wire [31:0] rd_shifted = rd_word_ff >> rd_sh;
  wire have_byte = (pad_ff != 2'h0) | (len_ff != 14'h0000);
  wire more_after = (pad_ff != 2'h0) ? ((pad_ff != 2'h1) | (len_ff != 14'h0000)) :
    (len_ff != 14'h0001);
  wire shifter_empty;
  wire out_load = (state_ff == S_ROUT) & ((dum_ff != 8'h00) | have_byte);
  wire [7:0] out_byte = (dum_ff != 8'h00) ? `DUMMY_FILL : rd_shifted[7:0];

  lane_shifter u_shift (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .fall(fall),
    .clr(~active),
    .quad(is_quad_ff),
    .load(out_load),
    .load_byte(out_byte),
    .empty(shifter_empty),
    .lanes_out_ff(serial_data_lines_out),
    .lanes_oe_ff(serial_data_lines_oe)
  );

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_ff <= 1'b0;
      state_ff <= S_IDLE;
      in_sr_ff <= 8'h00;
      in_cnt_ff <= 3'h0;
      addr_hi_done_ff <= 1'b0;
      addr_ff <= 16'h0000;
      is_quad_ff <= 1'b0;
      is_wr_ff <= 1'b0;
      len_ff <= 14'h0000;
      pad_ff <= 2'h0;
      dum_ff <= 8'h00;
      lane_ff <= 2'h0;
      rd_word_ff <= 32'h00000000;
      wr_dw_ff <= 12'h000;
      wr_word_ff <= 32'h00000000;
      wr_acc_be_ff <= 4'h0;
      rd_req_ff <= 1'b0;
      rd_dw_ff <= 14'h0000;
      wr_strobe_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      wr_data_ff <= 32'h00000000;
      wr_be_ff <= 4'h0;
      busy_ff <= 1'b0;
      cmd_reject_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
      busy_ff <= active;
      rd_req_ff <= 1'b0;
      wr_strobe_ff <= 1'b0;
      if (rd_ack) begin
        rd_word_ff <= rd_data;
      end
      if (!active) begin
        // partial dword is flushed at deselect unless compatibility mode
        if (is_wr_ff && (wr_acc_be_ff != 4'h0) && !compat_mode) begin
          wr_strobe_ff <= 1'b1;
          wr_addr_ff <= wr_dw_ff;
          wr_data_ff <= wr_word_ff;
          wr_be_ff <= wr_acc_be_ff;
        end
        wr_acc_be_ff <= 4'h0;
        is_wr_ff <= 1'b0;
        state_ff <= S_IDLE;
      end else if (state_ff == S_IDLE) begin
        in_cnt_ff <= 3'h0;
        addr_hi_done_ff <= 1'b0;
        dum_ff <= 8'h00;
        cmd_reject_ff <= 1'b0;
        state_ff <= S_OPC;
      end else begin
        if (rise && (state_ff != S_ROUT) && (state_ff != S_IGN)) begin
          in_sr_ff <= nxt_in_sr;
          in_cnt_ff <= byte_done ? 3'h0 : in_cnt_ff + 3'h1;
        end
        if (byte_done) begin
          case (state_ff)
            S_OPC: begin
              // i/o reads need single-lane protocol
              if (!quad_instruction_protocol && nxt_in_sr == `OPC_DUAL_IO_RD) begin
                is_quad_ff <= 1'b0;
                state_ff <= S_ADDR;
              end else if (!quad_instruction_protocol &&
                  nxt_in_sr == `OPC_QUAD_IO_RD) begin
                is_quad_ff <= 1'b1;
                state_ff <= S_ADDR;
              end else if (!quad_instruction_protocol && nxt_in_sr == WRITE_OPCODE) begin
                is_wr_ff <= 1'b1;
                state_ff <= S_ADDR;
              end else begin
                cmd_reject_ff <= 1'b1;
                state_ff <= S_IGN;
              end
            end
            S_ADDR: begin
              addr_ff <= nxt_addr;
              addr_hi_done_ff <= 1'b1;
              if (addr_hi_done_ff) begin
                if (is_wr_ff) begin
                  wr_dw_ff <= nxt_addr[13:2];
                  lane_ff <= nxt_addr[1:0];
                  dum_ff <= wr_dummy_init;
                  state_ff <= (wr_dummy_init == 8'h00) ? S_WDAT : S_WDUM;
                end else begin
                  // fetch early so the word is ready before output starts
                  rd_dw_ff <= nxt_addr[15:2];
                  rd_req_ff <= 1'b1;
                  lane_ff <= 2'h0;
                  pad_ff <= nxt_addr[1:0];
                  state_ff <= S_LEN1;
                end
              end
            end
            S_LEN1: begin
              if (nxt_in_sr[`LEN_EXT_BIT]) begin
                len_ff <= {nxt_in_sr[6:0], `LEN_ZERO7};
                state_ff <= S_LEN2;
              end else begin
                len_ff <= {`LEN_ZERO7, nxt_in_sr[6:0]};
                dum_ff <= rd_dummy_init;
                state_ff <= (rd_dummy_init == 8'h00) ? S_ROUT : S_RDUM;
              end
            end
            S_LEN2: begin
              len_ff <= {len_ff[13:7], nxt_in_sr[6:0]};
              dum_ff <= rd_dummy_init;
              state_ff <= (rd_dummy_init == 8'h00) ? S_ROUT : S_RDUM;
            end
            S_RDUM: begin
              // output begins on the next fall
              dum_ff <= dum_ff - 8'h01;
              if (dum_ff == 8'h01) begin
                state_ff <= S_ROUT;
              end
            end
            S_WDUM: begin
              dum_ff <= dum_ff - 8'h01;
              if (dum_ff == 8'h01) begin
                state_ff <= S_WDAT;
              end
            end
            S_WDAT: begin
              lane_ff <= lane_ff + 2'h1;
              if (lane_ff == `LANE_LAST) begin
                wr_strobe_ff <= 1'b1;
                wr_addr_ff <= wr_dw_ff;
                wr_data_ff <= nxt_wr_word;
                wr_be_ff <= wr_acc_be_ff | lane_bit;
                wr_acc_be_ff <= 4'h0;
                // reserved code 11 is treated as constant
                case (addr_ff[`MODE_HI:`MODE_LO])
                  `MODE_INC: wr_dw_ff <= wr_dw_ff + `WR_DW_STEP;
                  `MODE_DEC: wr_dw_ff <= wr_dw_ff - `WR_DW_STEP;
                  default: wr_dw_ff <= wr_dw_ff;
                endcase
                dum_ff <= wr_dummy_inter;
                if (wr_dummy_inter != 8'h00) begin
                  state_ff <= S_WDUM;
                end
              end else begin
                wr_word_ff <= nxt_wr_word;
                wr_acc_be_ff <= wr_acc_be_ff | lane_bit;
                dum_ff <= wr_dummy_intra;
                if (wr_dummy_intra != 8'h00) begin
                  state_ff <= S_WDUM;
                end
              end
            end
            default: state_ff <= state_ff;
          endcase
        end
        if (fall && shifter_empty && out_load) begin
          // each byte or dummy follows the previous one with no gap
          if (dum_ff != 8'h00) begin
            dum_ff <= dum_ff - 8'h01;
          end else begin
            lane_ff <= lane_ff + 2'h1;
            if (pad_ff != 2'h0) begin
              pad_ff <= pad_ff - 2'h1;
            end else begin
              len_ff <= len_ff - 14'h0001;
            end
            // nothing trails the last byte
            if (!more_after) begin
              dum_ff <= 8'h00;
            end else if (lane_ff == `LANE_LAST) begin
              dum_ff <= rd_dummy_inter;
              rd_dw_ff <= rd_dw_ff + `RD_DW_STEP;
              rd_req_ff <= 1'b1;
            end else begin
              dum_ff <= rd_dummy_intra;
            end
          end
        end
      end
    end
  end

endmodule // serial_multi_io_slave

/* hw/serial_slave_map.vh */
// constants for the multi-lane serial host interface slave
`ifndef SERIAL_SLAVE_MAP_VH
`define SERIAL_SLAVE_MAP_VH

`define OPC_DUAL_IO_RD 8'hbb
`define OPC_QUAD_IO_RD 8'heb
`define OPC_WRITE_DEF 8'h02

`define MODE_CONST 2'b00
`define MODE_INC 2'b01
`define MODE_DEC 2'b10
`define MODE_HI 15
`define MODE_LO 14

`define LEN_EXT_BIT 7
`define LEN_ZERO7 7'h00

`define GRP_LAST_X1 3'h7
`define GRP_LAST_X2 3'h3
`define GRP_LAST_X4 3'h1

`define LANE_LAST 2'h3
`define RD_DW_STEP 14'h0001
`define WR_DW_STEP 12'h001
`define DUMMY_FILL 8'h00
`define BYTE_MASK 32'h000000ff

`define OE_X2 4'h3
`define OE_X4 4'hf
`define OE_OFF 4'h0

`endif

/* hw/sync_2ff.v */
// two-stage synchroniser for signals from outside the ref_clk domain
`timescale 1ns/1ps
module sync_2ff #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // signals
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out_ff
);

  reg [WIDTH-1:0] meta_ff;

  // first stage is read by the second stage only
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_out_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_out_ff <= meta_ff;
    end
  end

endmodule // sync_2ff

/* hw/lane_shifter.v */
// output byte shifter, two or four lanes, advanced on serial clock falls
`timescale 1ns/1ps
`include "serial_slave_map.vh"
module lane_shifter (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // control
  input wire fall,
  input wire clr,
  input wire quad,
  input wire load,
  input wire [7:0] load_byte,
  // status
  output wire empty,
  // pins
  output reg [3:0] lanes_out_ff,
  output reg [3:0] lanes_oe_ff
);

  reg [7:0] sr_ff;
  reg [1:0] grp_ff;

  assign empty = (grp_ff == 2'h0);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_ff <= 8'h00;
      grp_ff <= 2'h0;
      lanes_out_ff <= 4'h0;
      lanes_oe_ff <= `OE_OFF;
    end else if (clr) begin
      grp_ff <= 2'h0;
      lanes_oe_ff <= `OE_OFF;
    end else if (fall) begin
      if (load && empty) begin
        // msb group of the byte goes out first
        if (quad) begin
          lanes_out_ff <= load_byte[7:4];
          sr_ff <= {load_byte[3:0], 4'h0};
          grp_ff <= 2'h1;
          lanes_oe_ff <= `OE_X4;
        end else begin
          lanes_out_ff <= {2'b00, load_byte[7:6]};
          sr_ff <= {load_byte[5:0], 2'b00};
          grp_ff <= 2'h3;
          lanes_oe_ff <= `OE_X2;
        end
      end else if (!empty) begin
        lanes_out_ff <= quad ? sr_ff[7:4] : {2'b00, sr_ff[7:6]};
        sr_ff <= quad ? {sr_ff[3:0], 4'h0} : {sr_ff[5:0], 2'b00};
        grp_ff <= grp_ff - 2'h1;
      end
    end
  end

endmodule // lane_shifter

/* tb/serial_multi_io_monitor.sv */
// assertion checker for the multi-lane serial slave
`timescale 1ns/1ps
module serial_multi_io_monitor (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // observed ports
  input wire serial_clk,
  input wire serial_select_n,
  input wire [3:0] serial_data_lines_out,
  input wire [3:0] serial_data_lines_oe,
  input wire quad_instruction_protocol,
  input wire rd_req_ff,
  input wire [13:0] rd_dw_ff,
  input wire wr_strobe_ff,
  input wire [3:0] wr_be_ff,
  input wire busy_ff,
  input wire cmd_reject_ff
);
  wire [3:0] oe;
  assign oe = serial_data_lines_oe;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  oe_code_a: assert property (
    oe inside {4'h0, 4'h3, 4'hf}) else $error("bad lane enable");
  dual_lanes_a: assert property (
    oe == 4'h3 |-> serial_data_lines_out[3:2] == 2'b00) else $error("dual upper lanes");
  release_a: assert property (
    $rose(serial_select_n) |-> ##[1:6] oe == 4'h0) else $error("lanes not released");
  refuse_quiet_a: assert property (
    cmd_reject_ff || quad_instruction_protocol |-> oe == 4'h0) else $error("refused but drives");
  out_on_fall_a: assert property (
    $changed(serial_data_lines_out) |-> !serial_clk) else $error("output moved on high clock");
  wr_pulse_a: assert property (
    wr_strobe_ff |-> wr_be_ff != 4'h0 ##1 !wr_strobe_ff) else $error("bad write strobe");
  rd_pulse_a: assert property (
    rd_req_ff |=> !rd_req_ff) else $error("fetch pulse too long");
  dw_hold_a: assert property (
    $changed(rd_dw_ff) |-> rd_req_ff) else $error("fetch index moved alone");
  busy_a: assert property (
    !serial_select_n [*5] |-> busy_ff) else $error("busy missing");
  cover property (oe == 4'h3);
  cover property (oe == 4'hf);
  cover property (wr_strobe_ff && wr_be_ff != 4'hf);
  cover property (cmd_reject_ff);
endmodule // serial_multi_io_monitor

bind serial_multi_io_slave serial_multi_io_monitor mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(serial_clk),
  .serial_select_n(serial_select_n), .serial_data_lines_out(serial_data_lines_out),
  .serial_data_lines_oe(serial_data_lines_oe),
  .quad_instruction_protocol(quad_instruction_protocol), .rd_req_ff(rd_req_ff),
  .rd_dw_ff(rd_dw_ff), .wr_strobe_ff(wr_strobe_ff), .wr_be_ff(wr_be_ff),
  .busy_ff(busy_ff), .cmd_reject_ff(cmd_reject_ff));

/* tb/spi_host_model.sv */
// host master model driving the serial link
`timescale 1ns/1ps
module spi_host_model (
  // link pins
  output reg serial_clk,
  output reg serial_select_n,
  output reg [3:0] host_d,
  input wire [3:0] line_lvl
);
  initial begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    host_d = 4'h0;
  end
  // clock stays low outside frames
  task start;
    begin
      serial_select_n = 1'b0;
      #100;
    end
  endtask
  task stop;
    begin
      #100;
      serial_select_n = 1'b1;
      host_d = ~host_d;
      #400;
    end
  endtask
  // msb first, w lines per clock, data changes on the fall
  task send(input [31:0] v, input integer n, input integer w);
    integer i;
    reg [3:0] m;
    begin
      m = w == 1 ? 4'h1 : w == 2 ? 4'h3 : 4'hf;
      for (i = n - w; i >= 0; i = i - w) begin
        host_d = v[i +: 4] & m;
        #62.5 serial_clk = 1'b1;
        #62.5 serial_clk = 1'b0;
      end
    end
  endtask
  // released lines toggle so stale levels never look valid
  task recv(input integer w, output [7:0] b);
    integer i;
    begin
      b = 8'h00;
      for (i = 0; i < 8 / w; i = i + 1) begin
        host_d = ~host_d;
        #62.5 serial_clk = 1'b1;
        b = w == 2 ? {b[5:0], line_lvl[1:0]} : {b[3:0], line_lvl};
        #62.5 serial_clk = 1'b0;
      end
    end
  endtask
endmodule // spi_host_model

/* tb/tb_serial_multi_io_slave.sv */
// self-checking bench for the multi-lane serial slave
`timescale 1ns/1ps
module tb_serial_multi_io_slave;
  reg ref_clk, rst_n, qip, compat_mode;
  reg rd_ack = 1'b0, pend_ff = 1'b0;
  reg [7:0] rdi, rda, rde, wdi, wda, wde;
  reg [31:0] rd_data = 32'h0;
  wire [3:0] dout, doe, host_d, lvl, wr_be_ff;
  wire sclk, ssel_n, rd_req_ff, wr_strobe_ff, busy_ff, cmd_reject_ff;
  wire [13:0] rd_dw_ff;
  wire [11:0] wr_addr_ff;
  wire [31:0] wr_data_ff;
  integer miscompares, checks_done;
  integer cyc = 0;
  reg [47:0] wq[$];
  reg [47:0] eq[$];
  assign lvl = (dout & doe) | (host_d & ~doe);
  spi_host_model host (.serial_clk(sclk), .serial_select_n(ssel_n), .host_d(host_d),
    .line_lvl(lvl));
  serial_multi_io_slave dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(sclk), .serial_select_n(ssel_n),
    .serial_data_lines_in(lvl), .serial_data_lines_out(dout), .serial_data_lines_oe(doe),
    .quad_instruction_protocol(qip), .compat_mode(compat_mode),
    .rd_dummy_init(rdi), .rd_dummy_intra(rda), .rd_dummy_inter(rde),
    .wr_dummy_init(wdi), .wr_dummy_intra(wda), .wr_dummy_inter(wde),
    .rd_req_ff(rd_req_ff), .rd_dw_ff(rd_dw_ff), .rd_ack(rd_ack), .rd_data(rd_data),
    .wr_strobe_ff(wr_strobe_ff), .wr_addr_ff(wr_addr_ff), .wr_data_ff(wr_data_ff),
    .wr_be_ff(wr_be_ff), .busy_ff(busy_ff), .cmd_reject_ff(cmd_reject_ff));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function [7:0] lb(input [1:0] n);
    lb = {rd_dw_ff[5:0], n} ^ 8'h5a;
  endfunction
  function [31:0] msk(input [3:0] b);
    msk = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction
  // register file answers two cycles after a fetch; data churns otherwise
  always @(negedge ref_clk) begin
    pend_ff <= rd_req_ff;
    rd_ack <= pend_ff;
    rd_data <= pend_ff ? {lb(2'd3), lb(2'd2), lb(2'd1), lb(2'd0)} : ~rd_data;
    if (wr_strobe_ff === 1'b1)
      wq.push_back({wr_addr_ff, wr_be_ff, wr_data_ff & msk(wr_be_ff)});
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task chk(input [47:0] got, input [47:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rd(input [7:0] op, input integer w, input [15:0] a, input [13:0] len);
    reg [15:0] k;
    reg [7:0] b;
    begin
      host.start;
      host.send(32'(op), 8, 1);
      host.send(32'(a), 16, w);
      if (len > 14'd127)
        host.send({16'h0, 1'b1, len[13:7], 1'b0, len[6:0]}, 16, w);
      else
        host.send(32'(len[6:0]), 8, w);
      repeat (rdi) host.send(32'ha5, 8, w);
      for (k = {a[15:2], 2'b00}; k < a + 16'(len); k = k + 16'h1) begin
        host.recv(w, b);
        chk(48'(b), 48'(k[7:0] ^ 8'h5a));
        if (k + 16'h1 < a + 16'(len))
          repeat (k[1:0] == 2'd3 ? rde : rda) begin
            host.recv(w, b);
            chk(48'(b), 48'h0);
          end
      end
      host.stop;
      chk(48'(doe), 48'h0);
    end
  endtask
  task wr(input [15:0] a, input integer n);
    reg [11:0] dw;
    reg [3:0] be;
    reg [31:0] d;
    reg [1:0] ln;
    integer k;
    begin
      dw = a[13:2];
      be = 4'h0;
      d = 32'h0;
      host.start;
      host.send(32'h02, 8, 1);
      host.send(32'(a), 16, 1);
      repeat (wdi) host.send(32'h3c, 8, 1);
      for (k = 0; k < n; k = k + 1) begin
        ln = a[1:0] + k[1:0];
        host.send(32'h30 + k, 8, 1);
        be[ln] = 1'b1;
        d[{ln, 3'b000} +: 8] = 8'h30 + k[7:0];
        if (ln == 2'd3) begin
          eq.push_back({dw, be, d});
          dw = a[15:14] == 2'b01 ? dw + 12'h1 : a[15:14] == 2'b10 ? dw - 12'h1 : dw;
          be = 4'h0;
          d = 32'h0;
        end
        if (k < n - 1)
          repeat (ln == 2'd3 ? wde : wda) host.send(32'h3c, 8, 1);
      end
      if (be != 4'h0 && !compat_mode)
        eq.push_back({dw, be, d});
      host.stop;
      chk(48'(wq.size()), 48'(eq.size()));
      while (eq.size() > 0 && wq.size() > 0)
        chk(wq.pop_front(), eq.pop_front());
      wq.delete();
      eq.delete();
    end
  endtask
  task rej(input [7:0] op);
    begin
      host.start;
      host.send(32'(op), 8, 1);
      host.send(32'h0, 16, 1);
      #300;
      chk(48'({cmd_reject_ff, doe}), 48'h10);
      host.stop;
    end
  endtask
  task t_dual;
    begin
      @(negedge ref_clk);
      rdi = 8'd2;
      rda = 8'd0;
      rde = 8'd0;
      rd(8'hbb, 2, 16'h0005, 14'd6);
    end
  endtask
  task t_quad;
    begin
      @(negedge ref_clk);
      rdi = 8'd4;
      rda = 8'd1;
      rde = 8'd2;
      rd(8'heb, 4, 16'h0022, 14'd130);
    end
  endtask
  task t_writes;
    integer m;
    begin
      @(negedge ref_clk);
      wdi = 8'd1;
      wda = 8'd0;
      wde = 8'd1;
      for (m = 0; m < 3; m = m + 1)
        wr({m[1:0], 14'h0010}, 8);
    end
  endtask
  // unaligned partial write, then a short write that compat mode must drop
  task t_partial;
    begin
      @(negedge ref_clk);
      wde = 8'd0;
      wr(16'h4002, 3);
      @(negedge ref_clk);
      compat_mode = 1'b1;
      wr(16'h4000, 2);
      @(negedge ref_clk);
      compat_mode = 1'b0;
    end
  endtask
  task t_reject;
    begin
      @(negedge ref_clk);
      qip = 1'b1;
      rej(8'hbb);
      rej(8'heb);
      @(negedge ref_clk);
      qip = 1'b0;
      rej(8'h9f);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    {rst_n, qip, compat_mode} = 3'h0;
    {rdi, rda, rde, wdi, wda, wde} = 48'h0;
    miscompares = 0;
    checks_done = 0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    t_dual;
    t_quad;
    t_writes;
    t_partial;
    t_reject;
    final_report;
  end
endmodule // tb_serial_multi_io_slave
